/* File: lb_defs.svh */
/*
 * Offsets, field positions, reset values and frame figures of the
 * maintenance loopback pattern generator and its CRC error counter.
 * Assumes it is included by bare name, once per compilation unit.
 */
// Summary of operation
// - 8-bit pattern selector, read/write, acts only when configured as center side.
// - Zero: 64-byte unicast 55AA; bit 0: 1518-byte unicast 55AA.
// - Bit 2: 1518-byte broadcast frames, payload word 55AA.
// - Bit 3: 64-byte unicast 0F0F; bit 4: 1518-byte unicast 0F0F.
// - Bit 5: 64-byte broadcast 0F0F; bit 6: 1518-byte broadcast 0F0F.
// - Bit 7: 1518-byte broadcast FF00; other selector values are unsupported.
// - Destination is address bytes one to five, then last address byte plus one.
// - Last destination byte increases by one for each further frame of a run.
// - Source is the six configured address bytes, unchanged.
// - Type/length field of every frame is 0800.
// - Center side counts returned frames with bad check sequence.
// - Counter value equals number of errored frames received, holding at FF.
// - Writing zero to packet-count register clears the error counter.
// - Frames per run come from packet-count register, 1 to 255, default 7.
`ifndef LB_DEFS_SVH
`define LB_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LB_IDX_PKT_COUNT 8'h44
`define LB_IDX_PATTERN 8'h45
`define LB_IDX_CRC_ERR 8'h46
`define LB_IDX_ADDR_FIRST 8'h52
`define LB_IDX_ADDR_LAST 8'h57
`define LB_IDX_CTRL 8'h60
`define LB_IDX_INT_STS 8'h61
`define LB_IDX_INT_MASK 8'h62

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define LB_CTRL_CENTER 0
`define LB_CTRL_START 1
`define LB_INT_DONE 0
`define LB_INT_CRC 1
`define LB_RST_PKT_COUNT 8'h07
`define LB_RST_PATTERN 8'h00
`define LB_RST_ADDR_BYTE 8'h00

// ----------------------------------------------------------------
// Frame figures
// ----------------------------------------------------------------
`define LB_LAST_IDX_SHORT 11'd63
`define LB_LAST_IDX_LONG 11'd1517
`define LB_WORD_A 16'h55aa
`define LB_WORD_B 16'h0f0f
`define LB_WORD_C 16'hff00
`define LB_TYPE_HI 8'h08
`define LB_TYPE_LO 8'h00
`define LB_CRC_INIT 32'hffff_ffff
`define LB_CRC_POLY 32'hedb8_8320

`endif

/* File: lb_pkg.sv */
/*
 * Types shared by the loopback pattern generator.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lb_pkg;

	// ----------------------------------------------------------------
	// Generator states
	// ----------------------------------------------------------------
	typedef enum logic {GEN_IDLE, GEN_SEND} gen_state_e;

	// ----------------------------------------------------------------
	// Decoded frame shape
	// ----------------------------------------------------------------
	typedef struct packed {
		logic long_frame;
		logic bcast;
		logic [15:0] word;
	} frame_cfg_s;

	// ----------------------------------------------------------------
	// Whole block state
	// ----------------------------------------------------------------
	typedef struct packed {
		gen_state_e st;
		logic center;
		logic [7:0] pkt_count;
		logic [7:0] pattern;
		logic [7:0] crc_err;
		logic [5:0][7:0] mac;
		logic [1:0] int_sts;
		logic [1:0] int_mask;
		frame_cfg_s cfg;
		logic [10:0] idx;
		logic [7:0] sent;
		logic [7:0] da_last;
		logic [31:0] crc;
		logic [7:0] tx_data;
		logic [7:0] prdata;
	} core_s;

endpackage

/* File: lb_crc32_byte.sv */
/*
 * One byte step of the Ethernet frame check sequence, reflected form.
 * Assumes the caller holds the running value and inverts it at the end.
 */
`timescale 1ns/1ps
`include "lb_defs.svh"

module lb_crc32_byte (
	input wire logic [31:0] crc_in,
	input wire logic [7:0] data,
	output logic [31:0] crc_out
);

	// Bitwise shift, least significant bit first as on the wire
	always_comb begin
		logic [31:0] c;
		c = crc_in;
		for (int b = 0; b < 8; b++) begin
			if (c[0] ^ data[b]) begin
				c = (c >> 1) ^ `LB_CRC_POLY;
			end else begin
				c = c >> 1;
			end
		end
		crc_out = c;
	end

endmodule // lb_crc32_byte

/* File: loopback_pattern_crc_counter.sv */
/*
 * Center-side maintenance loopback test: frame generator with
 * selectable pattern, APB register file and CRC error counter.
 * Assumes a byte stream sink with valid/ready on pclk, and a receive
 * path on pclk that pulses rx_done with rx_crc_bad per returned frame.
 */
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "lb_defs.svh"

module loopback_pattern_crc_counter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [7:0] tx_data,
	output logic tx_valid,
	output logic tx_last,
	input wire logic tx_ready,
	input wire logic rx_done,
	input wire logic rx_crc_bad,
	output logic irq
);

	lb_pkg::core_s q;
	lb_pkg::core_s n;
	logic [7:0] reg_idx;
	logic mapped;
	logic apb_wr;
	logic apb_rd_setup;
	logic fire;
	logic cnt_clear;
	logic crc_evt;
	logic [31:0] crc_upd;
	logic [10:0] last_idx;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// One-hot selector to frame shape; unsupported codes fall to the zero shape
	function automatic lb_pkg::frame_cfg_s pattern_decode(input logic [7:0] sel);
		lb_pkg::frame_cfg_s c;
		c = '{long_frame: 1'b0, bcast: 1'b0, word: `LB_WORD_A};
		case (sel)
			8'h01: c = '{long_frame: 1'b1, bcast: 1'b0, word: `LB_WORD_A};
			8'h04: c = '{long_frame: 1'b1, bcast: 1'b1, word: `LB_WORD_A};
			8'h08: c = '{long_frame: 1'b0, bcast: 1'b0, word: `LB_WORD_B};
			8'h10: c = '{long_frame: 1'b1, bcast: 1'b0, word: `LB_WORD_B};
			8'h20: c = '{long_frame: 1'b0, bcast: 1'b1, word: `LB_WORD_B};
			8'h40: c = '{long_frame: 1'b1, bcast: 1'b1, word: `LB_WORD_B};
			8'h80: c = '{long_frame: 1'b1, bcast: 1'b1, word: `LB_WORD_C};
			default: c = '{long_frame: 1'b0, bcast: 1'b0, word: `LB_WORD_A};
		endcase
		return c;
	endfunction

	function automatic logic [10:0] frame_last(input lb_pkg::frame_cfg_s c);
		return c.long_frame ? `LB_LAST_IDX_LONG : `LB_LAST_IDX_SHORT;
	endfunction

	// Byte at a given frame position; crc is the running value so far
	function automatic logic [7:0] frame_byte(input logic [10:0] i,
		input lb_pkg::frame_cfg_s c, input logic [7:0] da_last,
		input logic [5:0][7:0] mac, input logic [31:0] crc);
		logic [10:0] fcs_at;
		logic [10:0] off;
		logic [31:0] fcs;
		fcs_at = 11'(frame_last(c) - 11'd3);
		off = 11'(i - 11'd6);
		fcs = ~crc;
		if (i < 11'd6) begin
			if (c.bcast) begin
				return 8'hff;
			end
			return (i == 11'd5) ? da_last : mac[i[2:0]];
		end else if (i < 11'd12) begin
			return mac[off[2:0]];
		end else if (i == 11'd12) begin
			return `LB_TYPE_HI;
		end else if (i == 11'd13) begin
			return `LB_TYPE_LO;
		end else if (i < fcs_at) begin
			// Payload offset parity equals index parity
			return i[0] ? c.word[7:0] : c.word[15:8];
		end
		off = 11'(i - fcs_at);
		return fcs[8*off[1:0] +: 8];
	endfunction

	// ----------------------------------------------------------------
	// Bus decode and stream handshake
	// ----------------------------------------------------------------

	// Slave never waits; unmapped or unaligned words answer with an error
	assign reg_idx = paddr[9:2];
	assign mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
		((reg_idx >= `LB_IDX_PKT_COUNT && reg_idx <= `LB_IDX_CRC_ERR) ||
		(reg_idx >= `LB_IDX_ADDR_FIRST && reg_idx <= `LB_IDX_ADDR_LAST) ||
		(reg_idx >= `LB_IDX_CTRL && reg_idx <= `LB_IDX_INT_MASK));
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign apb_wr = psel && penable && pwrite && mapped;
	assign apb_rd_setup = psel && !penable && !pwrite;
	assign prdata = {24'h00_0000, q.prdata};
	assign tx_valid = (q.st == lb_pkg::GEN_SEND);
	assign tx_data = q.tx_data;
	assign last_idx = frame_last(q.cfg);
	assign tx_last = tx_valid && (q.idx == last_idx);
	assign fire = tx_valid && tx_ready;
	assign irq = |(q.int_sts & q.int_mask);
	assign cnt_clear = apb_wr && (reg_idx == `LB_IDX_PKT_COUNT) && (pwdata[7:0] == 8'h00);
	assign crc_evt = rx_done && rx_crc_bad && q.center;

	// Running check value over the byte now on the stream
	lb_crc32_byte u_crc (
		.crc_in(q.crc),
		.data(q.tx_data),
		.crc_out(crc_upd)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] crc_nx;
		logic [7:0] sent_nx;
		logic [1:0] int_set;
		logic [7:0] rd;
		logic [7:0] aoff;
		n = q;
		crc_nx = q.crc;
		sent_nx = 8'(q.sent + 8'd1);
		int_set = 2'b00;
		rd = 8'h00;
		aoff = 8'(reg_idx - `LB_IDX_ADDR_FIRST);

		// Read data latched in the setup cycle, so it is stable in access
		if (reg_idx == `LB_IDX_PKT_COUNT) rd = q.pkt_count;
		else if (reg_idx == `LB_IDX_PATTERN) rd = q.pattern;
		else if (reg_idx == `LB_IDX_CRC_ERR) rd = q.crc_err;
		else if (reg_idx >= `LB_IDX_ADDR_FIRST && reg_idx <= `LB_IDX_ADDR_LAST) rd = q.mac[aoff[2:0]];
		else if (reg_idx == `LB_IDX_CTRL) rd = {6'b00_0000, tx_valid, q.center};
		else if (reg_idx == `LB_IDX_INT_STS) rd = {6'b00_0000, q.int_sts};
		else if (reg_idx == `LB_IDX_INT_MASK) rd = {6'b00_0000, q.int_mask};
		if (apb_rd_setup) begin
			n.prdata = mapped ? rd : 8'h00;
		end

		// Plain configuration writes
		if (apb_wr) begin
			if (reg_idx == `LB_IDX_PKT_COUNT) n.pkt_count = pwdata[7:0];
			if (reg_idx == `LB_IDX_PATTERN) n.pattern = pwdata[7:0];
			if (reg_idx >= `LB_IDX_ADDR_FIRST && reg_idx <= `LB_IDX_ADDR_LAST) begin
				n.mac[aoff[2:0]] = pwdata[7:0];
			end
			if (reg_idx == `LB_IDX_CTRL) n.center = pwdata[`LB_CTRL_CENTER];
			if (reg_idx == `LB_IDX_INT_MASK) n.int_mask = pwdata[1:0];
		end

		// Generator; a start while busy is ignored so a run is never cut short
		case (q.st)
			lb_pkg::GEN_IDLE: begin
				if (apb_wr && reg_idx == `LB_IDX_CTRL && pwdata[`LB_CTRL_START] && q.center) begin
					if (q.pkt_count == 8'h00) begin
						int_set[`LB_INT_DONE] = 1'b1;
					end else begin
						n.cfg = pattern_decode(q.pattern);
						n.da_last = 8'(q.mac[5] + 8'd1);
						n.idx = 11'd0;
						n.sent = 8'h00;
						n.crc = `LB_CRC_INIT;
						n.tx_data = frame_byte(11'd0, n.cfg, n.da_last, q.mac, `LB_CRC_INIT);
						n.st = lb_pkg::GEN_SEND;
					end
				end
			end
			lb_pkg::GEN_SEND: begin
				if (fire) begin
					// check value frozen once the sequence bytes start
					if (q.idx < 11'(last_idx - 11'd3)) crc_nx = crc_upd;
					if (q.idx == last_idx) begin
						n.sent = sent_nx;
						if (sent_nx >= q.pkt_count) begin
							n.st = lb_pkg::GEN_IDLE;
							int_set[`LB_INT_DONE] = 1'b1;
						end else begin
							n.da_last = 8'(q.da_last + 8'd1);
							n.idx = 11'd0;
							n.crc = `LB_CRC_INIT;
							n.tx_data = frame_byte(11'd0, q.cfg, n.da_last, q.mac, `LB_CRC_INIT);
						end
					end else begin
						n.idx = 11'(q.idx + 11'd1);
						n.crc = crc_nx;
						n.tx_data = frame_byte(n.idx, q.cfg, q.da_last, q.mac, crc_nx);
					end
				end
			end
			default: n.st = lb_pkg::GEN_IDLE;
		endcase

		// saturating count, an arriving error beats the clear
		if (cnt_clear) begin
			n.crc_err = crc_evt ? 8'h01 : 8'h00;
		end else if (crc_evt && q.crc_err != 8'hff) begin
			n.crc_err = 8'(q.crc_err + 8'd1);
		end
		int_set[`LB_INT_CRC] = crc_evt;

		// Write-one-to-clear status; a new event wins over the clear
		if (apb_wr && reg_idx == `LB_IDX_INT_STS) begin
			n.int_sts = q.int_sts & ~pwdata[1:0];
		end
		n.int_sts = n.int_sts | int_set;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.pkt_count <= `LB_RST_PKT_COUNT;
			q.pattern <= `LB_RST_PATTERN;
			q.mac <= {6{`LB_RST_ADDR_BYTE}};
			q.crc <= `LB_CRC_INIT;
			q.st <= lb_pkg::GEN_IDLE;
		end else begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Last frame of a run once this byte is taken
	function automatic logic sent_done();
		return 8'(q.sent + 8'd1) >= q.pkt_count;
	endfunction

	// Frame length is checked against the selector itself, not against the decode
	AST_FRAME_LEN: assert property ($rose(tx_valid) |->
		q.cfg.long_frame == (q.pattern inside {8'h01, 8'h04, 8'h10, 8'h40, 8'h80}))
		else $error("frame length differs from selected pattern");

	AST_BCAST_DA: assert property (fire && q.idx < 11'd6 && q.cfg.bcast |->
		tx_data == 8'hff)
		else $error("broadcast destination byte not all ones");

	AST_PAYLOAD: assert property (fire && q.idx >= 11'd14 &&
		q.idx < 11'(last_idx - 11'd3) |->
		tx_data == (q.idx[0] ? q.cfg.word[7:0] : q.cfg.word[15:8]))
		else $error("payload byte does not match pattern word");

	AST_DA_FIRST: assert property (tx_valid && !$past(tx_valid) |->
		q.da_last == 8'($past(q.mac[5]) + 8'd1))
		else $error("first destination last byte not address plus one");

	AST_DA_STEP: assert property (fire && tx_last && tx_valid ##1 tx_valid |->
		q.da_last == 8'($past(q.da_last) + 8'd1))
		else $error("destination last byte did not step by one");

	AST_SA_LAST: assert property (fire && q.idx == 11'd11 |->
		tx_data == q.mac[5])
		else $error("source last byte altered");

	AST_TYPE: assert property (fire && q.idx == 11'd12 |->
		tx_data == `LB_TYPE_HI ##1 (!fire || tx_data == `LB_TYPE_LO))
		else $error("type field is not 0800");

	AST_START_CENTER: assert property ($rose(tx_valid) |-> $past(q.center))
		else $error("run started while not center side");

	AST_RUN_END: assert property (fire && tx_last && sent_done() |=> !tx_valid)
		else $error("run sent more frames than configured");

	AST_CRC_INC: assert property (crc_evt && !cnt_clear && q.crc_err != 8'hff |=>
		q.crc_err == 8'($past(q.crc_err) + 8'd1))
		else $error("error counter did not count bad frame");

	AST_CRC_SAT: assert property (q.crc_err == 8'hff && !cnt_clear |=>
		q.crc_err == 8'hff)
		else $error("error counter wrapped");

	AST_CRC_CLR: assert property (cnt_clear && !crc_evt |=> q.crc_err == 8'h00)
		else $error("error counter not cleared");

	COV_BCAST_FRAME: cover property (fire && tx_last && q.cfg.bcast);
	COV_LONG_FRAME: cover property (fire && tx_last && q.cfg.long_frame);
	COV_CRC_COUNT: cover property (crc_evt ##1 q.crc_err != 8'h00);
	COV_IRQ: cover property ($rose(irq));

endmodule // loopback_pattern_crc_counter

/* File: lb_sink.sv */
/*
 * Far-side model: accepts the generated byte stream, keeps the last
 * frame, and reports each frame back as returned with good or bad FCS.
 * Assumes the generator and this model share pclk and presetn.
 */
`timescale 1ns/1ps

module lb_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_last,
	output logic tx_ready,
	output logic rx_done,
	output logic rx_crc_bad,
	input wire logic slow,
	input wire logic bad
);
	logic [7:0] mem [0:1517];
	int cnt;
	int len;
	int frames;

	// ----------------------------------------------------------------
	// Capture and return
	// ----------------------------------------------------------------
	// Stalls every other cycle when slow; error flag is junk outside rx_done
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ready <= 1'b0;
			rx_done <= 1'b0;
			rx_crc_bad <= 1'b0;
			cnt <= 0;
			len <= 0;
			frames <= 0;
		end else begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
			rx_done <= 1'b0;
			rx_crc_bad <= ~rx_crc_bad;
			if (tx_valid && tx_ready) begin
				if (cnt < 1518)
					mem[cnt] <= tx_data;
				cnt <= cnt + 1;
				if (tx_last) begin
					len <= cnt + 1;
					cnt <= 0;
					frames <= frames + 1;
					rx_done <= 1'b1;
					rx_crc_bad <= bad;
				end
			end
		end
	end
endmodule // lb_sink

/* File: tb_loopback_pattern_crc_counter.sv */
/*
 * Self-checking bench for the loopback generator and CRC counter.
 * Assumes lb_pkg, lb_defs.svh and the design files compile first.
 */
`timescale 1ns/1ps

module tb_loopback_pattern_crc_counter;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [7:0] tx_data;
	logic tx_valid, tx_last, tx_ready, rx_done, rx_crc_bad, slow, bad;
	int bad_count = 0;
	int samples_checked = 0;
	logic [7:0] mac [0:5] = '{8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'hfe};

	loopback_pattern_crc_counter loopback_pattern_crc_counter_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_last(tx_last), .tx_ready(tx_ready), .rx_done(rx_done),
		.rx_crc_bad(rx_crc_bad), .irq(irq));
	lb_sink lb_sink_inst (.pclk(pclk), .presetn(presetn), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
		.rx_done(rx_done), .rx_crc_bad(rx_crc_bad), .slow(slow), .bad(bad));

	// ----------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Ceiling is about twice the expected run length
	initial begin
		repeat (80000) @(posedge pclk);
		bad_count++;
		final_report();
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer; released only after pready is seen high
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h00_0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, idx, d, r, e);
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] r);
		logic e;
		apb(1'b0, idx, 8'h00, r, e);
	endtask

	// Start a run of n frames and wait for the done flag
	// Center side goes in first: a start only counts once it is in force
	task automatic run(input logic [7:0] n);
		int k;
		wr(8'h44, n);
		wr(8'h60, 8'h01);
		wr(8'h60, 8'h03);
		k = 0;
		rv = 32'h0000_0000;
		while (rv[0] !== 1'b1 && k < 10000) begin
			rd(8'h61, rv);
			k++;
		end
		if (k == 10000)
			bad_count++;
		wr(8'h61, 8'h01);
	endtask

	// Judge the last captured frame
	task automatic chk_frame(input logic lng, input logic bc, input logic [15:0] w,
		input logic [7:0] dl);
		int n;
		logic [31:0] c;
		n = lng ? 1518 : 64;
		c = 32'hffff_ffff;
		chk(lb_sink_inst.len, n);
		for (int k = 0; k < 6; k++)
			chk(lb_sink_inst.mem[k], bc ? 8'hff : (k == 5 ? dl : mac[k]));
		for (int k = 0; k < 6; k++)
			chk(lb_sink_inst.mem[6 + k], mac[k]);
		chk({lb_sink_inst.mem[12], lb_sink_inst.mem[13]}, 16'h0800);
		for (int k = 14; k < n - 4; k++)
			chk(lb_sink_inst.mem[k], k[0] ? w[7:0] : w[15:8]);
		for (int k = 0; k < n - 4; k++) begin
			c = c ^ lb_sink_inst.mem[k];
			for (int b = 0; b < 8; b++)
				c = c[0] ? (c >> 1) ^ 32'hedb8_8320 : c >> 1;
		end
		c = ~c;
		chk({lb_sink_inst.mem[n - 1], lb_sink_inst.mem[n - 2],
			lb_sink_inst.mem[n - 3], lb_sink_inst.mem[n - 4]}, c);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic e;
		rd(8'h44, rv);
		chk(rv, 32'h0000_0007);
		rd(8'h45, rv);
		chk(rv, 32'h0000_0000);
		wr(8'h46, 8'hff);
		rd(8'h46, rv);
		chk(rv, 32'h0000_0000);
		apb(1'b0, 8'h70, 8'h00, rv, e);
		chk(rv, 32'h0000_0000);
		chk({31'h0000_0000, e}, 32'h0000_0001);
		$display("reset test done");
	endtask

	// Every selector value, plus an unsupported one that acts as zero
	task automatic t_patterns();
		logic [7:0] sel [0:8] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h10, 8'h20,
			8'h40, 8'h80, 8'h02};
		logic [15:0] wd [0:8] = '{16'h55aa, 16'h55aa, 16'h55aa, 16'h0f0f,
			16'h0f0f, 16'h0f0f, 16'h0f0f, 16'hff00, 16'h55aa};
		logic [8:0] lng = 9'h0d6;
		logic [8:0] bc = 9'h0e4;
		for (int k = 0; k < 6; k++)
			wr(8'h52 + k[7:0], mac[k]);
		slow <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			wr(8'h45, sel[i]);
			rd(8'h45, rv);
			chk(rv, {24'h00_0000, sel[i]});
			run(8'h01);
			chk_frame(lng[i], bc[i], wd[i], 8'hff);
		end
		$display("pattern test done");
	endtask

	task automatic t_increment();
		int f;
		wr(8'h45, 8'h00);
		f = lb_sink_inst.frames;
		run(8'h03);
		chk(lb_sink_inst.frames - f, 3);
		chk_frame(1'b0, 1'b0, 16'h55aa, 8'h01);
		$display("increment test done");
	endtask

	task automatic t_errors();
		slow <= 1'b0;
		bad <= 1'b1;
		run(8'h02);
		rd(8'h46, rv);
		chk(rv, 32'h0000_0002);
		// Interrupt line is looked at once the register write has settled
		wr(8'h62, 8'h00);
		@(negedge pclk);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		wr(8'h62, 8'h02);
		@(negedge pclk);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		wr(8'h61, 8'h02);
		@(negedge pclk);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		wr(8'h44, 8'h00);
		rd(8'h46, rv);
		chk(rv, 32'h0000_0000);
		repeat (3) run(8'h64);
		rd(8'h46, rv);
		chk(rv, 32'h0000_00ff);
		bad <= 1'b0;
		$display("error counter test done");
	endtask

	task automatic t_side();
		int f;
		f = lb_sink_inst.frames;
		wr(8'h60, 8'h00);
		wr(8'h60, 8'h02);
		repeat (40) @(posedge pclk);
		chk(lb_sink_inst.frames, f);
		$display("side test done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		slow = 1'b0;
		bad = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_patterns();
		t_increment();
		t_errors();
		t_side();
		final_report();
	end
endmodule // tb_loopback_pattern_crc_counter
